/* core/bank1_sfr_pkg.sv */
/*
 * constants for the bank 1 special register file: register indices,
 * reset values, writable-bit masks, address layout and bus figures.
 * assumes an apb slave with 32-bit data, one register per aligned word.
 */
package bank1_sfr_pkg;

    // ------------------------------------------------------------------
    // address layout
    // ------------------------------------------------------------------
    localparam int ADDR_W = 11;            // byte address, 4 banks x 128
    localparam int INDEX_W = 9;            // register index width
    localparam int SLOT_W = 5;             // slots within bank 1 window
    localparam int NUM_SLOTS = 32;         // indices 0x80 to 0x9f
    localparam int DATA_W = 32;            // apb data width
    localparam int REG_W = 8;              // register width
    localparam int PC_HI_W = 5;            // program counter bits 12:8
    localparam logic [1:0] BANK_ONE = 2'h1;

    // ------------------------------------------------------------------
    // register indices; byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [INDEX_W-1:0] IDX_INDIRECT_DATA_PORT = 9'h080;
    localparam logic [INDEX_W-1:0] IDX_OPTION_CONFIG = 9'h081;
    localparam logic [INDEX_W-1:0] IDX_PROGRAM_COUNTER_LOW = 9'h082;
    localparam logic [INDEX_W-1:0] IDX_CPU_STATUS = 9'h083;
    localparam logic [INDEX_W-1:0] IDX_INDIRECT_POINTER = 9'h084;
    localparam logic [INDEX_W-1:0] IDX_PORT_A_DIRECTION = 9'h085;
    localparam logic [INDEX_W-1:0] IDX_PORT_B_DIRECTION = 9'h086;
    localparam logic [INDEX_W-1:0] IDX_PC_HIGH_LATCH = 9'h08a;
    localparam logic [INDEX_W-1:0] IDX_INTERRUPT_CONTROL = 9'h08b;
    localparam logic [INDEX_W-1:0] IDX_PERIPHERAL_IRQ_ENABLE_1 = 9'h08c;
    localparam logic [INDEX_W-1:0] IDX_PERIPHERAL_IRQ_ENABLE_2 = 9'h08d;
    localparam logic [INDEX_W-1:0] IDX_RESET_CAUSE = 9'h08e;
    localparam logic [INDEX_W-1:0] IDX_OSCILLATOR_CONTROL = 9'h08f;
    localparam logic [INDEX_W-1:0] IDX_OSCILLATOR_TRIM = 9'h090;
    localparam logic [INDEX_W-1:0] IDX_TIMER2_PERIOD = 9'h092;
    localparam logic [INDEX_W-1:0] IDX_SERIAL_SLAVE_ADDRESS = 9'h093;
    localparam logic [INDEX_W-1:0] IDX_SERIAL_PORT_STATUS = 9'h094;
    localparam logic [INDEX_W-1:0] IDX_ADC_RESULT_LOW = 9'h09e;
    localparam logic [INDEX_W-1:0] IDX_ADC_CONFIG_1 = 9'h09f;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [REG_W-1:0] RST_ZERO = 8'h00;
    localparam logic [REG_W-1:0] RST_ONES = 8'hff;
    localparam logic [REG_W-1:0] RST_CPU_STATUS = 8'h18;
    localparam logic [REG_W-1:0] RST_RESET_CAUSE = 8'h00;

    // ------------------------------------------------------------------
    // writable bit masks; other bits are fixed or hardware owned
    // ------------------------------------------------------------------
    localparam logic [REG_W-1:0] WM_ALL = 8'hff;
    localparam logic [REG_W-1:0] WM_NONE = 8'h00;
    localparam logic [REG_W-1:0] WM_CPU_STATUS = 8'he7;
    localparam logic [REG_W-1:0] WM_PORT_A_DIRECTION = 8'hdf;
    localparam logic [REG_W-1:0] WM_PC_HIGH_LATCH = 8'h1f;
    localparam logic [REG_W-1:0] WM_PERIPHERAL_IRQ_ENABLE_1 = 8'h4f;
    localparam logic [REG_W-1:0] WM_PERIPHERAL_IRQ_ENABLE_2 = 8'h10;
    localparam logic [REG_W-1:0] WM_RESET_CAUSE = 8'h03;
    localparam logic [REG_W-1:0] WM_OSC_CONTROL = 8'h70;
    localparam logic [REG_W-1:0] WM_OSC_TRIM = 8'h3f;
    localparam logic [REG_W-1:0] WM_SERIAL_STATUS = 8'hc0;
    localparam logic [REG_W-1:0] WM_ADC_CONFIG_1 = 8'hcf;

    // ------------------------------------------------------------------
    // bits that read back a live hardware level
    // ------------------------------------------------------------------
    localparam int OSC_STABLE_BIT = 2;
    localparam int SERIAL_STATUS_LIVE_W = 6;

endpackage

/* core/bank1_sfr.sv */
/*
 * bank 1 special register file with an apb slave port.
 * assumes the cpu core (or a bench) acts as apb master on pclk, and that
 * the indirect data path and peripheral status levels are synchronous.
 */
// Overview of operation
// - unimplemented locations and bits read zero, ignore writes
// - common registers mirrored in every bank
// - pc high latch loads pc 12:8 on pc write
// - pc upper byte has no register address
// - port a pin 5 direction bit reads one
// - indirect pointer holds indirect address, undefined after reset
`timescale 1ns/10ps
`default_nettype none

module bank1_sfr
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [bank1_sfr_pkg::ADDR_W-1:0] paddr,
    input wire logic [bank1_sfr_pkg::DATA_W-1:0] pwdata,
    output logic [bank1_sfr_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // indirect data path
    input wire logic [bank1_sfr_pkg::REG_W-1:0] indirect_rd_data,
    output logic indirect_wr_strobe,
    output logic [bank1_sfr_pkg::REG_W-1:0] indirect_wr_data,
    output logic [bank1_sfr_pkg::REG_W-1:0] indirect_addr,
    // hardware status levels
    input wire logic osc_stable,
    input wire logic [bank1_sfr_pkg::SERIAL_STATUS_LIVE_W-1:0] serial_live,
    input wire logic [bank1_sfr_pkg::REG_W-1:0] adc_result_low_in,
    // register contents toward the core and peripherals
    output logic [bank1_sfr_pkg::PC_HI_W+bank1_sfr_pkg::REG_W-1:0] pc_out,
    output logic [bank1_sfr_pkg::REG_W-1:0] option_out,
    output logic [bank1_sfr_pkg::REG_W-1:0] port_a_dir_out,
    output logic [bank1_sfr_pkg::REG_W-1:0] port_b_dir_out,
    output logic [bank1_sfr_pkg::REG_W-1:0] timer2_period_out,
    output logic [bank1_sfr_pkg::REG_W-1:0] interrupt_control_out
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------

    // slot of a bank 1 index within the storage array
    function automatic logic [bank1_sfr_pkg::SLOT_W-1:0] slot_of
    (
        input logic [bank1_sfr_pkg::INDEX_W-1:0] idx
    );
        slot_of = idx[bank1_sfr_pkg::SLOT_W-1:0];
    endfunction

    // writable bits per index; zero mask means no stored bits (holes, indirect data port, adc result low)
    function automatic logic [bank1_sfr_pkg::REG_W-1:0] write_mask
    (
        input logic [bank1_sfr_pkg::INDEX_W-1:0] idx
    );
        unique case (idx)
            bank1_sfr_pkg::IDX_OPTION_CONFIG,
            bank1_sfr_pkg::IDX_PROGRAM_COUNTER_LOW,
            bank1_sfr_pkg::IDX_INDIRECT_POINTER,
            bank1_sfr_pkg::IDX_PORT_B_DIRECTION,
            bank1_sfr_pkg::IDX_INTERRUPT_CONTROL,
            bank1_sfr_pkg::IDX_TIMER2_PERIOD,
            bank1_sfr_pkg::IDX_SERIAL_SLAVE_ADDRESS:
                write_mask = bank1_sfr_pkg::WM_ALL;
            bank1_sfr_pkg::IDX_CPU_STATUS:
                write_mask = bank1_sfr_pkg::WM_CPU_STATUS;
            bank1_sfr_pkg::IDX_PORT_A_DIRECTION:
                write_mask = bank1_sfr_pkg::WM_PORT_A_DIRECTION;
            bank1_sfr_pkg::IDX_PC_HIGH_LATCH:
                write_mask = bank1_sfr_pkg::WM_PC_HIGH_LATCH;
            bank1_sfr_pkg::IDX_PERIPHERAL_IRQ_ENABLE_1:
                write_mask = bank1_sfr_pkg::WM_PERIPHERAL_IRQ_ENABLE_1;
            bank1_sfr_pkg::IDX_PERIPHERAL_IRQ_ENABLE_2:
                write_mask = bank1_sfr_pkg::WM_PERIPHERAL_IRQ_ENABLE_2;
            bank1_sfr_pkg::IDX_RESET_CAUSE:
                write_mask = bank1_sfr_pkg::WM_RESET_CAUSE;
            bank1_sfr_pkg::IDX_OSCILLATOR_CONTROL:
                write_mask = bank1_sfr_pkg::WM_OSC_CONTROL;
            bank1_sfr_pkg::IDX_OSCILLATOR_TRIM:
                write_mask = bank1_sfr_pkg::WM_OSC_TRIM;
            bank1_sfr_pkg::IDX_SERIAL_PORT_STATUS:
                write_mask = bank1_sfr_pkg::WM_SERIAL_STATUS;
            bank1_sfr_pkg::IDX_ADC_CONFIG_1:
                write_mask = bank1_sfr_pkg::WM_ADC_CONFIG_1;
            default:
                write_mask = bank1_sfr_pkg::WM_NONE;
        endcase
    endfunction

    // power-on value per slot
    function automatic logic [bank1_sfr_pkg::REG_W-1:0] reset_value
    (
        input logic [bank1_sfr_pkg::INDEX_W-1:0] idx
    );
        unique case (idx)
            bank1_sfr_pkg::IDX_OPTION_CONFIG,
            bank1_sfr_pkg::IDX_PORT_A_DIRECTION,
            bank1_sfr_pkg::IDX_PORT_B_DIRECTION,
            bank1_sfr_pkg::IDX_TIMER2_PERIOD:
                reset_value = bank1_sfr_pkg::RST_ONES;
            bank1_sfr_pkg::IDX_CPU_STATUS:
                reset_value = bank1_sfr_pkg::RST_CPU_STATUS;
            bank1_sfr_pkg::IDX_RESET_CAUSE:
                reset_value = bank1_sfr_pkg::RST_RESET_CAUSE;
            default:
                reset_value = bank1_sfr_pkg::RST_ZERO;
        endcase
    endfunction

    // resolve any bank address to a bank 1 index, or flag it unmapped
    function automatic logic [bank1_sfr_pkg::INDEX_W:0] resolve
    (
        input logic [bank1_sfr_pkg::INDEX_W-1:0] idx
    );
        logic [bank1_sfr_pkg::INDEX_W-1:0] b1;
        logic common;
        b1 = {bank1_sfr_pkg::BANK_ONE, idx[bank1_sfr_pkg::INDEX_W-3:0]};
        // common registers answer from every bank
        common = (b1 == bank1_sfr_pkg::IDX_INDIRECT_DATA_PORT)
            || (b1 == bank1_sfr_pkg::IDX_PROGRAM_COUNTER_LOW)
            || (b1 == bank1_sfr_pkg::IDX_CPU_STATUS)
            || (b1 == bank1_sfr_pkg::IDX_INDIRECT_POINTER)
            || (b1 == bank1_sfr_pkg::IDX_PC_HIGH_LATCH)
            || (b1 == bank1_sfr_pkg::IDX_INTERRUPT_CONTROL)
            || (b1 == bank1_sfr_pkg::IDX_OSCILLATOR_TRIM);
        if (common || idx[bank1_sfr_pkg::INDEX_W-1:bank1_sfr_pkg::INDEX_W-2]
            == bank1_sfr_pkg::BANK_ONE)
        begin
            resolve = {1'b1, b1};
        end
        else
        begin
            resolve = {1'b0, b1}; // other banks are out of this block
        end
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [bank1_sfr_pkg::REG_W-1:0] regs_reg [bank1_sfr_pkg::NUM_SLOTS];
    logic [bank1_sfr_pkg::REG_W-1:0] regs_next [bank1_sfr_pkg::NUM_SLOTS];
    logic [bank1_sfr_pkg::PC_HI_W-1:0] pc_upper_reg; // no bus address
    logic [bank1_sfr_pkg::PC_HI_W-1:0] pc_upper_next;
    logic pready_reg;
    logic pready_next;
    logic [bank1_sfr_pkg::DATA_W-1:0] prdata_reg;
    logic [bank1_sfr_pkg::DATA_W-1:0] prdata_next;
    logic ind_wr_reg;
    logic ind_wr_next;
    logic [bank1_sfr_pkg::REG_W-1:0] ind_data_reg;
    logic [bank1_sfr_pkg::REG_W-1:0] ind_data_next;

    // decode of the current request
    logic [bank1_sfr_pkg::INDEX_W:0] hit; // mapped flag and index
    logic [bank1_sfr_pkg::INDEX_W-1:0] idx; // bank 1 index
    logic aligned; // low address bits zero
    logic mapped; // request lands on this bank
    logic complete; // access phase ends at this edge
    logic [bank1_sfr_pkg::REG_W-1:0] rd_byte; // value seen by a read
    logic [bank1_sfr_pkg::REG_W-1:0] wmask; // writable bits of target

    assign hit = resolve(paddr[bank1_sfr_pkg::ADDR_W-1:2]);
    assign idx = hit[bank1_sfr_pkg::INDEX_W-1:0];
    assign aligned = (paddr[1:0] == 2'h0);
    assign mapped = hit[bank1_sfr_pkg::INDEX_W] && aligned;
    assign complete = psel && penable && pready_reg;
    assign wmask = mapped ? write_mask(idx) : bank1_sfr_pkg::WM_NONE;

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------

    // stored bits merged with live hardware bits; unmapped reads zero
    always_comb
    begin
        rd_byte = regs_reg[slot_of(idx)] & write_mask(idx);
        unique case (idx)
            bank1_sfr_pkg::IDX_INDIRECT_DATA_PORT:
                rd_byte = indirect_rd_data; // data at the pointed address
            bank1_sfr_pkg::IDX_CPU_STATUS,
            bank1_sfr_pkg::IDX_PORT_A_DIRECTION:
                rd_byte = regs_reg[slot_of(idx)];
            bank1_sfr_pkg::IDX_OSCILLATOR_CONTROL:
                rd_byte[bank1_sfr_pkg::OSC_STABLE_BIT] = osc_stable;
            bank1_sfr_pkg::IDX_SERIAL_PORT_STATUS:
                rd_byte[bank1_sfr_pkg::SERIAL_STATUS_LIVE_W-1:0] =
                    serial_live;
            bank1_sfr_pkg::IDX_ADC_RESULT_LOW:
                rd_byte = adc_result_low_in;
            default:
            begin
            end
        endcase
        if (!mapped)
        begin
            rd_byte = bank1_sfr_pkg::RST_ZERO;
        end
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------

    // one wait state: read data is captured while pready rises, so that
    // prdata and pready leave a flip-flop directly; pslverr is tied to zero
    always_comb
    begin
        regs_next = regs_reg;
        pc_upper_next = pc_upper_reg;
        pready_next = psel && penable && !pready_reg;
        prdata_next = prdata_reg;
        ind_wr_next = 1'b0;
        ind_data_next = ind_data_reg;
        if (pready_next && !pwrite)
        begin
            prdata_next = {{(bank1_sfr_pkg::DATA_W-bank1_sfr_pkg::REG_W){1'b0}},
                rd_byte};
        end
        if (complete && pwrite)
        begin
            // only writable bits change; the rest keep their value
            regs_next[slot_of(idx)] = (regs_reg[slot_of(idx)] & ~wmask)
                | (pwdata[bank1_sfr_pkg::REG_W-1:0] & wmask);
            if (mapped && idx == bank1_sfr_pkg::IDX_PROGRAM_COUNTER_LOW)
            begin
                // upper pc byte only moves when the low byte is loaded
                pc_upper_next = regs_reg[slot_of(
                    bank1_sfr_pkg::IDX_PC_HIGH_LATCH)]
                    [bank1_sfr_pkg::PC_HI_W-1:0];
            end
            if (mapped && idx == bank1_sfr_pkg::IDX_INDIRECT_DATA_PORT)
            begin
                // forwarded to memory at the pointer address
                ind_wr_next = 1'b1;
                ind_data_next = pwdata[bank1_sfr_pkg::REG_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------

    // pointer has no defined power-on value; it is cleared only so the
    // hardware never carries unknowns
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < bank1_sfr_pkg::NUM_SLOTS; i++)
            begin
                regs_reg[i] <= reset_value({bank1_sfr_pkg::BANK_ONE,
                    2'h0, i[bank1_sfr_pkg::SLOT_W-1:0]});
            end
            pc_upper_reg <= '0;
            pready_reg <= 1'b0;
            prdata_reg <= '0;
            ind_wr_reg <= 1'b0;
            ind_data_reg <= '0;
        end
        else
        begin
            regs_reg <= regs_next;
            pc_upper_reg <= pc_upper_next;
            pready_reg <= pready_next;
            prdata_reg <= prdata_next;
            ind_wr_reg <= ind_wr_next;
            ind_data_reg <= ind_data_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = 1'b0; // unmapped reads answer zero, never an error
    assign indirect_wr_strobe = ind_wr_reg;
    assign indirect_wr_data = ind_data_reg;
    assign indirect_addr =
        regs_reg[slot_of(bank1_sfr_pkg::IDX_INDIRECT_POINTER)];
    assign pc_out = {pc_upper_reg,
        regs_reg[slot_of(bank1_sfr_pkg::IDX_PROGRAM_COUNTER_LOW)]};
    assign option_out = regs_reg[slot_of(bank1_sfr_pkg::IDX_OPTION_CONFIG)];
    assign port_a_dir_out =
        regs_reg[slot_of(bank1_sfr_pkg::IDX_PORT_A_DIRECTION)];
    assign port_b_dir_out =
        regs_reg[slot_of(bank1_sfr_pkg::IDX_PORT_B_DIRECTION)];
    assign timer2_period_out =
        regs_reg[slot_of(bank1_sfr_pkg::IDX_TIMER2_PERIOD)];
    assign interrupt_control_out =
        regs_reg[slot_of(bank1_sfr_pkg::IDX_INTERRUPT_CONTROL)];

endmodule

`default_nettype wire

/* bench/bank1_sfr_chk.sv */
/*
 * concurrent checks on the ports of the bank 1 register file.
 * assumes one clock pclk and the asynchronous active-low presetn.
 */
`timescale 1ns/10ps
`default_nettype none

module bank1_sfr_chk
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [10:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    // register contents
    input wire logic indirect_wr_strobe,
    input wire logic [7:0] indirect_wr_data,
    input wire logic [7:0] indirect_addr,
    input wire logic [12:0] pc_out,
    input wire logic [7:0] option_out,
    input wire logic [7:0] port_a_dir_out
);
    // --------------------
    // helpers
    // --------------------
    logic wr_done;     // a write completes at this edge
    logic [6:0] low7;  // offset within a bank, mirrors share it
    assign wr_done = psel && penable && pready && pwrite && paddr[1:0] == 2'h0;
    assign low7 = paddr[8:2];
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // --------------------
    // properties
    // --------------------
    property p_hi_zero;
        pready |-> prdata[31:8] == 24'h0;
    endproperty
    a_hi_zero: assert property (p_hi_zero)
        else $error("upper read bits set");
    property p_unmapped;
        pready && !pwrite && paddr[10:2] == 9'h087 |-> prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("hole reads nonzero");
    property p_pc_load;
        wr_done && low7 == 7'h02 |=> pc_out[7:0] == $past(pwdata[7:0]);
    endproperty
    a_pc_load: assert property (p_pc_load)
        else $error("pc low not loaded");
    property p_pc_hold;
        !(wr_done && low7 == 7'h02) |=> $stable(pc_out);
    endproperty
    a_pc_hold: assert property (p_pc_hold)
        else $error("pc moved alone");
    property p_ptr;
        wr_done && low7 == 7'h04 |=> indirect_addr == $past(pwdata[7:0]);
    endproperty
    a_ptr: assert property (p_ptr)
        else $error("pointer not loaded");
    property p_strobe;
        wr_done && low7 == 7'h00 |=> indirect_wr_strobe &&
            indirect_wr_data == $past(pwdata[7:0]) ##1 !indirect_wr_strobe;
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("bad indirect write");
    property p_pin5;
        port_a_dir_out[5] == 1'b1;
    endproperty
    a_pin5: assert property (p_pin5)
        else $error("pin 5 direction low");
    property p_pin5_rd;
        pready && !pwrite && paddr[10:2] == 9'h085 |-> prdata[5];
    endproperty
    a_pin5_rd: assert property (p_pin5_rd)
        else $error("pin 5 reads zero");
    property p_rst;
        $rose(presetn) |-> option_out == 8'hff && port_a_dir_out == 8'hff;
    endproperty
    a_rst: assert property (p_rst)
        else $error("bad reset value");
    c_pcl: cover property (wr_done && low7 == 7'h02);
    c_ind: cover property (indirect_wr_strobe);
    c_mirror: cover property (wr_done && paddr[10:9] != 2'h1 && low7 == 7'h04);
endmodule

bind bank1_sfr bank1_sfr_chk chk_inst (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .indirect_wr_strobe,
    .indirect_wr_data, .indirect_addr, .pc_out, .option_out, .port_a_dir_out);
`default_nettype wire

/* bench/testbench.sv */
/*
 * self-checking bench: reset values, masked writes, mirrors, pc load,
 * indirect writes. assumes an apb slave; every wait is bounded.
 */
`timescale 1ns/10ps
`default_nettype none

module testbench;
    // --------------------
    // signals
    // --------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [10:0] paddr = 11'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, ind_stb, osc_ok = 1'b0;
    logic [7:0] ind_rd = 8'h00, adc_lo = 8'h00, ind_wd, ind_addr;
    logic [5:0] ser_live = 6'h00;
    logic [7:0] opt_o, pa_o, pb_o, t2_o, ic_o;
    logic [12:0] pc_out, pcm;   // pcm: expected program counter
    logic [7:0] mdl [0:31];     // expected stored bits per slot
    logic [31:0] seed = 32'h52e7d6c7, rd;
    logic [4:0] sl;
    logic [7:0] d;
    logic [1:0] bw, br;         // banks used to write and read
    logic [1:0] lo = 2'h0;      // low address bits of the next transfer
    int n_fail = 0;
    int compares = 0;

    always #50 pclk = ~pclk;

    bank1_sfr bank1_sfr_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .indirect_rd_data(ind_rd), .indirect_wr_strobe(ind_stb),
        .indirect_wr_data(ind_wd), .indirect_addr(ind_addr),
        .osc_stable(osc_ok), .serial_live(ser_live),
        .adc_result_low_in(adc_lo), .pc_out(pc_out), .option_out(opt_o),
        .port_a_dir_out(pa_o), .port_b_dir_out(pb_o),
        .timer2_period_out(t2_o), .interrupt_control_out(ic_o));

    // --------------------
    // expectation functions
    // --------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // writable bits; holes have none so they keep reading zero
    function automatic logic [7:0] wm(input logic [4:0] s);
        case (s)
            5'h01, 5'h02, 5'h04, 5'h06, 5'h0b, 5'h12, 5'h13: return 8'hff;
            5'h03: return 8'he7;
            5'h05: return 8'hdf;
            5'h0a: return 8'h1f;
            5'h0c: return 8'h4f;
            5'h0d: return 8'h10;
            5'h0e: return 8'h03;
            5'h0f: return 8'h70;
            5'h10: return 8'h3f;
            5'h14: return 8'hc0;
            5'h1f: return 8'hcf;
            default: return 8'h00;
        endcase
    endfunction
    function automatic logic [7:0] rv(input logic [4:0] s);
        case (s)
            5'h01, 5'h05, 5'h06, 5'h12: return 8'hff;
            5'h03: return 8'h18;
            default: return 8'h00;
        endcase
    endfunction
    // read value: stored bits merged with live hardware levels
    function automatic logic [31:0] ex(input logic [4:0] s);
        case (s)
            5'h00: return {24'h0, ind_rd};
            5'h0f: return {24'h0, mdl[s] | {5'h0, osc_ok, 2'h0}};
            5'h14: return {24'h0, mdl[s] | {2'h0, ser_live}};
            5'h1e: return {24'h0, adc_lo};
            default: return {24'h0, mdl[s]};
        endcase
    endfunction
    function automatic logic cmn(input logic [4:0] s);
        return s inside {5'h00, 5'h02, 5'h03, 5'h04, 5'h0a, 5'h0b, 5'h10};
    endfunction

    // --------------------
    // tasks
    // --------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; live inputs get fresh random levels meanwhile
    task automatic apb(input logic w, input logic [8:0] idx,
                       input logic [7:0] dat);
        int n;
        rd = rnd();
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, lo};
        pwdata <= {rd[23:0], dat};
        {ind_rd, osc_ok, ser_live, adc_lo} <= rd[22:0];
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        chk({31'h0, pready}, 32'h1);
        chk({31'h0, pslverr}, 32'h0);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rst_check();
        pcm = 13'h0;
        for (int s = 0; s < 32; s++)
            mdl[s] = rv(s[4:0]);
        chk({opt_o, pa_o, pb_o, t2_o}, 32'hffffffff);
        chk({11'h0, ic_o, pc_out}, 32'h0);
        for (int s = 0; s < 32; s++)
            if (s != 4)
            begin
                apb(1'b0, {4'h4, s[4:0]}, 8'h00);
                chk(rd, ex(s[4:0]));
            end
    endtask
    task automatic end_sim();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // --------------------
    // main sequence
    // --------------------
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rst_check();
        // random writes, common slots through any bank, others elsewhere
        repeat (300)
        begin
            rd = rnd();
            sl = rd[4:0];
            d = rd[12:5];
            bw = cmn(sl) ? rd[14:13] : (rd[17] ? 2'h2 : 2'h1);
            br = cmn(sl) ? rd[16:15] : bw;
            apb(1'b1, {bw, 2'h0, sl}, d);
            if (bw == 2'h1 || cmn(sl))
                mdl[sl] = (mdl[sl] & ~wm(sl)) | (d & wm(sl));
            if (sl == 5'h02)
                pcm = {mdl[5'h0a][4:0], d};
            apb(1'b0, {br, 2'h0, sl}, 8'h00);
            chk(rd, (br == 2'h1 || cmn(sl)) ? ex(sl) : 32'h0);
            chk({19'h0, pc_out}, {19'h0, pcm});
        end
        chk({opt_o, pa_o, pb_o, t2_o}, {mdl[1],mdl[5],mdl[6],mdl[18]});
        chk({16'h0, ic_o, ind_addr}, {16'h0, mdl[11], mdl[4]});
        // misaligned transfers read zero and leave the register alone
        lo = 2'h1;
        apb(1'b1, 9'h081, ~mdl[1]);
        apb(1'b0, 9'h081, 8'h00);
        chk(rd, 32'h0);
        lo = 2'h0;
        apb(1'b0, 9'h081, 8'h00);
        chk(rd, {24'h0, mdl[1]});
        // latch alone leaves the counter, a pc low write copies it up
        apb(1'b1, 9'h18a, 8'hff);
        apb(1'b0, 9'h08a, 8'h00);
        chk(rd, 32'h1f);
        chk({19'h0, pc_out}, {19'h0, pcm});
        apb(1'b1, 9'h002, 8'h00);
        apb(1'b0, 9'h082, 8'h00);
        chk({19'h0, pc_out}, 32'h1f00);
        // indirect write through a mirror shows as a strobe next cycle
        apb(1'b1, 9'h100, 8'ha5);
        @(negedge pclk);
        chk({23'h0, ind_stb, ind_wd}, 32'h1a5);
        // reset in mid-run restores every value
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rst_check();
        end_sim();
    end

    // watchdog well beyond the few thousand cycles the run needs
    initial
    begin
        repeat (20000) @(posedge pclk);
        $display("Error at %0t: watchdog expired", $time);
        n_fail++;
        end_sim();
    end
endmodule
`default_nettype wire
